// *** hw/lamp_pkg.sv ***
// Shared constants, register map and carrier types of the status lamps.
// Assumes one 250 MHz clock and an APB master with 32-bit data.
package lamp_pkg;

  localparam int unsigned CLK_HZ    = 250_000_000;
  localparam int unsigned SLOW_HZ   = 1;
  localparam int unsigned FAST_HZ   = 10;
  localparam int unsigned SLOW_HALF = CLK_HZ / (2 * SLOW_HZ);
  localparam int unsigned FAST_HALF = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned FLASH_CNT_W = 27;

  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_LAMPS    = 8'h10;

  localparam int unsigned CTRL_LOCK_EN_BIT = 0;
  localparam int unsigned CTRL_BUS_VAR_BIT = 1;
  localparam logic        CTRL_LOCK_EN_RST = 1'b1;
  localparam logic        CTRL_BUS_VAR_RST = 1'b0;

  localparam int unsigned LAMP_DIAG_LSB = 0;
  localparam int unsigned LAMP_LINK_LSB = 2;
  localparam int unsigned LAMP_AXIS_LSB = 16;

  localparam int unsigned EV_BEAM = 0;
  localparam int unsigned EV_EXT  = 1;
  localparam int unsigned EV_INT  = 2;
  localparam int unsigned EV_WEAK = 3;
  localparam int unsigned EV_LINK = 4;
  localparam int unsigned EV_W    = 5;
  localparam logic [4:0]  IRQ_MASK_RST = 5'h00;

  localparam int unsigned ASI_ADDR_W = 5;

  typedef struct packed {
    logic red;
    logic green;
  } lamp_t;

  localparam lamp_t LAMP_OFF    = 2'h0;
  localparam lamp_t LAMP_GREEN  = 2'h1;
  localparam lamp_t LAMP_RED    = 2'h2;
  localparam lamp_t LAMP_YELLOW = 2'h3;

  typedef struct packed {
    logic [APB_AW-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic                  voltageOk;
    logic                  commOk;
    logic                  devErr;
    logic                  periphErr;
    logic [ASI_ADDR_W-1:0] addr;
  } asi_sense_t;

  typedef enum logic [0:0] {
    IL_LOCKED = 1'b0,
    IL_RUN    = 1'b1
  } ilock_state_t;

endpackage : lamp_pkg

// *** hw/flash_gen.sv ***
// Free-running divider giving the slow and fast lamp flash phases.
// Assumes sys_clk at the package rate; counts are parameters for sims.
`timescale 1ns/1ns
module flash_gen
  import lamp_pkg::*;
#(
  parameter int unsigned SLOW_CYC = SLOW_HALF,
  parameter int unsigned FAST_CYC = FAST_HALF
)
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  output logic      slowPhase,
  output logic      fastPhase
);

  typedef struct packed {
    logic [FLASH_CNT_W-1:0] slowCnt;
    logic [FLASH_CNT_W-1:0] fastCnt;
    logic                   slow;
    logic                   fast;
  } flash_st_t;

  localparam logic [FLASH_CNT_W-1:0] SLOW_END = FLASH_CNT_W'(SLOW_CYC - 1);
  localparam logic [FLASH_CNT_W-1:0] FAST_END = FLASH_CNT_W'(FAST_CYC - 1);

  flash_st_t st;
  flash_st_t nxt;

  // Equal half periods give a 50 percent duty cycle.
  always_comb
  begin
    nxt = st;
    nxt.slowCnt = (st.slowCnt == SLOW_END) ? '0 : st.slowCnt + 1'b1;
    nxt.fastCnt = (st.fastCnt == FAST_END) ? '0 : st.fastCnt + 1'b1;
    nxt.slow    = st.slow ^ (st.slowCnt == SLOW_END);
    nxt.fast    = st.fast ^ (st.fastCnt == FAST_END);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= nxt;
    end
  end

  assign slowPhase = st.slow;
  assign fastPhase = st.fast;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_slow_toggle: assert property (
    (st.slowCnt == SLOW_END) |=> (slowPhase != $past(slowPhase)))
    else $error("Slow phase did not toggle at end of half period.");
  chk_fast_hold: assert property (
    (st.fastCnt != FAST_END) |=> $stable(fastPhase))
    else $error("Fast phase changed inside a half period.");

endmodule : flash_gen

// *** hw/restart_interlock.sv ***
// Start/restart interlock driving the machine release output.
// Assumes the restart button and beam state are synchronous inputs.
`timescale 1ns/1ns
module restart_interlock
  import lamp_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic lockEn,
  input  wire logic beamBroken,
  input  wire logic restartButton,
  output logic      locked,
  output logic      releaseOut
);

  typedef struct packed {
    ilock_state_t mode;
    logic         btnPrev;
    logic         lockEnPrev;
  } ilock_st_t;

  ilock_st_t st;
  ilock_st_t nxt;
  logic      press;

  always_comb
  begin
    nxt = st;
    press = restartButton & ~st.btnPrev;
    nxt.btnPrev = restartButton;
    nxt.lockEnPrev = lockEn;
    unique case (st.mode)
      IL_LOCKED:
      begin
        // A clear field plus a button press frees it; with lockEn off a clear field alone does.
        if (!beamBroken && (press || !lockEn))
        begin
          nxt.mode = IL_RUN;
        end
      end
      IL_RUN:
      begin
        if ((beamBroken && lockEn) || (lockEn && !st.lockEnPrev))
        begin
          nxt.mode = IL_LOCKED;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '{mode: IL_LOCKED, default: '0};
    end
    else
    begin
      st <= nxt;
    end
  end

  // Gated without a flop so that a broken beam drops release at once.
  assign releaseOut = (st.mode == IL_RUN) && !beamBroken;
  assign locked     = (st.mode == IL_LOCKED) && lockEn;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_break_release: assert property (
    beamBroken |-> !releaseOut)
    else $error("Release output high while a beam is interrupted.");
  chk_no_autostart: assert property (
    (lockEn && $past(lockEn) && $rose(releaseOut))
      |-> $past(restartButton) && !$past(st.btnPrev))
    else $error("Release rose without a restart button press.");
  chk_break_locks: assert property (
    (lockEn && beamBroken) |=> (st.mode == IL_LOCKED))
    else $error("Beam break did not relock the interlock.");

endmodule : restart_interlock

// *** hw/status_lamps.sv ***
// Receiver status lamps, interlock and APB register slave.
// Assumes synchronous condition inputs and an APB master on sys_clk.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns

// Function
// - Axis lamp dark if beam inactive or unpowered.
// - External fault flashes diagnostic lamp red slowly.
// - Internal fault flashes diagnostic lamp red fast.
// - Weak signal flashes diagnostic lamp green slowly.
// - Locked interlock shows steady yellow outside bus variant; button releases.
// - Bus variant: no cable voltage, lamp dark.
// - Bus variant: no master communication, steady red.
// - Bus variant: address zero, yellow flashing.
// - Bus variant: device/link error, red-green alternating.
// - Bus variant: periphery error, green plus red flash.
// - Bus variant: normal communication, steady green.
// - Interlock holds release off until restart pressed.
// - Beam break drops release; no start while broken.
module status_lamps
  import lamp_pkg::*;
#(
  parameter int unsigned AXES     = 8,
  parameter int unsigned SLOW_CYC = SLOW_HALF,
  parameter int unsigned FAST_CYC = FAST_HALF
)
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire apb_req_t   apbReq,
  output apb_rsp_t        apbRsp,
  input  wire logic [AXES-1:0] beamActive,
  input  wire logic       txSupplyOk,
  input  wire logic [AXES-1:0] beamBlocked,
  input  wire logic       extFault,
  input  wire logic       intFault,
  input  wire logic       weakSignal,
  input  wire logic       restartButton,
  input  wire asi_sense_t asiSense,
  output logic [AXES-1:0] txAxisLamp,
  output lamp_t           diagLamp,
  output lamp_t           linkLamp,
  output logic            releaseOut,
  output logic            irq
);

  typedef struct packed {
    logic            lockEn;
    logic            busVariant;
    logic [EV_W-1:0] irqStat;
    logic [EV_W-1:0] irqMask;
    logic [EV_W-1:0] evPrev;
    lamp_t           diag;
    lamp_t           link;
    logic [AXES-1:0] axisLamp;
    logic [31:0]     rdata;
    logic            slverr;
  } top_st_t;

  localparam top_st_t ST_RESET = '{
    lockEn:     CTRL_LOCK_EN_RST,
    busVariant: CTRL_BUS_VAR_RST,
    irqMask:    IRQ_MASK_RST,
    default:    '0
  };

  top_st_t         st;
  top_st_t         nxt;
  logic            slowPhase;
  logic            fastPhase;
  logic            beamBroken;
  logic            locked;
  logic            setupPh;
  logic            wrAccess;
  logic [EV_W-1:0] evNow;
  logic [31:0]     rdWord;

  function automatic logic addrHit(input logic [APB_AW-1:0] a);
    addrHit = (a == OFS_CTRL) || (a == OFS_STATUS) ||
              (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK) ||
              (a == OFS_LAMPS);
  endfunction : addrHit

  function automatic lamp_t flashOf(input lamp_t c, input logic ph);
    flashOf = ph ? c : LAMP_OFF;
  endfunction : flashOf

  flash_gen #(
    .SLOW_CYC (SLOW_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_flash (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .slowPhase (slowPhase),
    .fastPhase (fastPhase)
  );

  restart_interlock u_ilock (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .lockEn        (st.lockEn),
    .beamBroken    (beamBroken),
    .restartButton (restartButton),
    .locked        (locked),
    .releaseOut    (releaseOut)
  );

  // Any single interrupted beam counts as a broken field.
  assign beamBroken = |beamBlocked;
  assign setupPh    = apbReq.psel && !apbReq.penable;
  assign wrAccess   = apbReq.psel && apbReq.penable && apbReq.pwrite;

  always_comb
  begin
    nxt = st;
    evNow = '0;
    evNow[EV_BEAM] = beamBroken;
    evNow[EV_EXT]  = extFault;
    evNow[EV_INT]  = intFault;
    evNow[EV_WEAK] = weakSignal;
    evNow[EV_LINK] = st.busVariant && !asiSense.commOk;

    // Axis lamp lit only with beam active and supply present.
    nxt.axisLamp = beamActive & {AXES{txSupplyOk}};

    if (intFault)
    begin
      nxt.diag = flashOf(LAMP_RED, fastPhase);
    end
    else if (extFault)
    begin
      nxt.diag = flashOf(LAMP_RED, slowPhase);
    end
    else if (weakSignal)
    begin
      nxt.diag = flashOf(LAMP_GREEN, slowPhase);
    end
    else
    begin
      nxt.diag = LAMP_OFF;
    end

    if (!st.busVariant)
    begin
      nxt.link = locked ? LAMP_YELLOW : LAMP_OFF;
    end
    else if (!asiSense.voltageOk)
    begin
      nxt.link = LAMP_OFF;
    end
    else if (asiSense.devErr)
    begin
      nxt.link = slowPhase ? LAMP_RED : LAMP_GREEN;
    end
    else if (asiSense.addr == '0)
    begin
      nxt.link = flashOf(LAMP_YELLOW, slowPhase);
    end
    else if (!asiSense.commOk)
    begin
      nxt.link = LAMP_RED;
    end
    else if (asiSense.periphErr)
    begin
      nxt.link = '{red: slowPhase, green: 1'b1};
    end
    else
    begin
      nxt.link = LAMP_GREEN;
    end

    rdWord = '0;
    unique case (apbReq.paddr)
      OFS_CTRL:
      begin
        rdWord[CTRL_LOCK_EN_BIT] = st.lockEn;
        rdWord[CTRL_BUS_VAR_BIT] = st.busVariant;
      end
      OFS_STATUS:
      begin
        rdWord[EV_W-1:0] = evNow;
        rdWord[EV_W]     = locked;
        rdWord[EV_W+1]   = releaseOut;
        rdWord[EV_W+2]   = asiSense.voltageOk;
      end
      OFS_IRQ_STAT: rdWord[EV_W-1:0] = st.irqStat;
      OFS_IRQ_MASK: rdWord[EV_W-1:0] = st.irqMask;
      OFS_LAMPS:
      begin
        rdWord[LAMP_DIAG_LSB +: 2]    = st.diag;
        rdWord[LAMP_LINK_LSB +: 2]    = st.link;
        rdWord[LAMP_AXIS_LSB +: AXES] = st.axisLamp;
      end
      default: rdWord = '0;
    endcase

    // Data is sampled in setup so the access phase needs no wait state.
    if (setupPh)
    begin
      nxt.rdata  = rdWord;
      nxt.slverr = !addrHit(apbReq.paddr);
    end

    if (wrAccess)
    begin
      unique case (apbReq.paddr)
        OFS_CTRL:
        begin
          nxt.lockEn     = apbReq.pwdata[CTRL_LOCK_EN_BIT];
          nxt.busVariant = apbReq.pwdata[CTRL_BUS_VAR_BIT];
        end
        OFS_IRQ_STAT: nxt.irqStat = st.irqStat & ~apbReq.pwdata[EV_W-1:0];
        OFS_IRQ_MASK: nxt.irqMask = apbReq.pwdata[EV_W-1:0];
        default: nxt.irqMask = st.irqMask;
      endcase
    end

    // A new event wins over a clear written in the same cycle.
    nxt.irqStat = nxt.irqStat | (evNow & ~st.evPrev);
    nxt.evPrev  = evNow;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= ST_RESET;
    end
    else
    begin
      st <= nxt;
    end
  end

  assign apbRsp.prdata  = st.rdata;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = st.slverr && apbReq.psel && apbReq.penable;
  assign txAxisLamp     = st.axisLamp;
  assign diagLamp       = st.diag;
  assign linkLamp       = st.link;
  assign irq            = |(st.irqStat & st.irqMask);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_axis_supply: assert property (
    !txSupplyOk |=> (txAxisLamp == '0))
    else $error("Axis lamp lit without transmitter supply.");
  chk_axis_beam: assert property (
    (txAxisLamp & ~$past(beamActive)) == '0)
    else $error("Axis lamp lit for an inactive beam.");
  chk_ext_slow: assert property (
    (extFault && !intFault)
      |=> (diagLamp == ($past(slowPhase) ? LAMP_RED : LAMP_OFF)))
    else $error("External fault lamp pattern wrong.");
  chk_int_fast: assert property (
    intFault |=> (diagLamp == ($past(fastPhase) ? LAMP_RED : LAMP_OFF)))
    else $error("Internal fault lamp pattern wrong.");
  chk_weak_green: assert property (
    (weakSignal && !extFault && !intFault)
      |=> (diagLamp == ($past(slowPhase) ? LAMP_GREEN : LAMP_OFF)))
    else $error("Weak signal lamp pattern wrong.");
  chk_diag_order: assert property (
    (intFault && (extFault || weakSignal)) ##1 $past(fastPhase)
      |-> (diagLamp == LAMP_RED))
    else $error("Internal fault did not take priority.");
  chk_lock_yellow: assert property (
    (!st.busVariant && locked) |=> (linkLamp == LAMP_YELLOW))
    else $error("Locked interlock not shown yellow.");
  chk_link_novolt: assert property (
    (st.busVariant && !asiSense.voltageOk) |=> (linkLamp == LAMP_OFF))
    else $error("Link lamp lit without cable voltage.");
  chk_link_nocomm: assert property (
    (st.busVariant && asiSense.voltageOk && !asiSense.devErr &&
     (asiSense.addr != '0) && !asiSense.commOk)
      |=> (linkLamp == LAMP_RED))
    else $error("Missing communication not shown red.");
  chk_link_addr0: assert property (
    (st.busVariant && asiSense.voltageOk && !asiSense.devErr &&
     (asiSense.addr == '0))
      |=> (linkLamp == ($past(slowPhase) ? LAMP_YELLOW : LAMP_OFF)))
    else $error("Address zero not shown as yellow flash.");
  chk_link_deverr: assert property (
    (st.busVariant && asiSense.voltageOk && asiSense.devErr)
      |=> (linkLamp == ($past(slowPhase) ? LAMP_RED : LAMP_GREEN)))
    else $error("Device error not shown red-green alternating.");
  chk_link_periph: assert property (
    (st.busVariant && asiSense.voltageOk && asiSense.commOk &&
     !asiSense.devErr && (asiSense.addr != '0) && asiSense.periphErr)
      |=> (linkLamp.green && (linkLamp.red == $past(slowPhase))))
    else $error("Periphery error pattern wrong.");
  chk_link_normal: assert property (
    (st.busVariant && asiSense.voltageOk && asiSense.commOk &&
     !asiSense.devErr && (asiSense.addr != '0) && !asiSense.periphErr)
      |=> (linkLamp == LAMP_GREEN))
    else $error("Normal communication not shown steady green.");
  chk_event_sticky: assert property (
    $rose(extFault) |=> st.irqStat[EV_EXT] [*2])
    else $error("External fault event not held in status.");

endmodule : status_lamps

// *** testbench/asi_partner.sv ***
// Behavioural bus master side: presents the sense lines of the link.
// Assumes the bench picks one link situation at a time through mode.
`timescale 1ns/1ns
module asi_partner
  import lamp_pkg::*;
(
  input  wire logic [2:0] mode,
  output asi_sense_t      asiSense
);
  // A slave without voltage or address cannot talk, so comm drops too.
  always_comb
  begin
    asiSense = '{voltageOk: 1'b1, commOk: 1'b1, devErr: 1'b0,
                 periphErr: 1'b0, addr: 5'h05};
    case (mode)
      3'h1: asiSense = '{1'b0, 1'b0, 1'b0, 1'b0, 5'h05};
      3'h2: asiSense.commOk = 1'b0;
      3'h3: asiSense = '{1'b1, 1'b0, 1'b0, 1'b0, 5'h00};
      3'h4: asiSense.devErr = 1'b1;
      3'h5: asiSense.periphErr = 1'b1;
      default: ;
    endcase
  end
endmodule : asi_partner

// *** testbench/status_lamps_tb.sv ***
// Self-checking bench of the status lamps, interlock and registers.
// Assumes short flash counts; lamp patterns are judged over 32 cycles.
`timescale 1ns/1ns
module status_lamps_tb
  import lamp_pkg::*;
;
  localparam int SC = 8;
  localparam int FC = 2;
  localparam int N  = 32;
  logic       sysClk;
  logic       rstN;
  apb_req_t   apbReq;
  apb_rsp_t   apbRsp;
  logic [7:0] beamActive;
  logic [7:0] beamBlocked;
  logic [7:0] txAxisLamp;
  logic       txSupplyOk;
  logic       extFault;
  logic       intFault;
  logic       weakSignal;
  logic       restartButton;
  logic       releaseOut;
  logic       irq;
  logic [2:0] asiMode;
  asi_sense_t asiSense;
  lamp_t      diagLamp;
  lamp_t      linkLamp;
  logic [31:0] rd;
  logic       err;
  int         failCount = 0;
  int         totalChecks = 0;
  logic [31:0] busExp [6] = '{32'h00200000, 32'h00002000, 32'h20000000,
                              32'h10102004, 32'h10100004, 32'h10201004};

  asi_partner i_partner (.mode(asiMode), .asiSense(asiSense));

  status_lamps #(.AXES(8), .SLOW_CYC(SC), .FAST_CYC(FC)) i_dut (
    .sys_clk(sysClk), .rst_n(rstN), .apbReq(apbReq), .apbRsp(apbRsp),
    .beamActive(beamActive), .txSupplyOk(txSupplyOk),
    .beamBlocked(beamBlocked), .extFault(extFault), .intFault(intFault),
    .weakSignal(weakSignal), .restartButton(restartButton),
    .asiSense(asiSense), .txAxisLamp(txAxisLamp), .diagLamp(diagLamp),
    .linkLamp(linkLamp), .releaseOut(releaseOut), .irq(irq));

  initial
  begin
    sysClk = 1'b0;
    forever #2 sysClk = ~sysClk;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    totalChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic closeOut();
    $display("Checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : closeOut

  // Waits on pready with no limit of its own; the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge sysClk);
    apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge sysClk);
    apbReq.penable <= 1'b1;
    do
    begin
      @(posedge sysClk);
    end
    while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  // Packs red-on, green-on, red-equals-green and change counts of a lamp.
  task automatic measure(input logic lnk, input logic [31:0] exp);
    lamp_t prev;
    lamp_t cur;
    int    r;
    int    g;
    int    s;
    int    t;
    {r, g, s, t} = '0;
    @(negedge sysClk);
    prev = lnk ? linkLamp : diagLamp;
    repeat (N)
    begin
      @(negedge sysClk);
      cur = lnk ? linkLamp : diagLamp;
      r += int'(cur.red === 1'b1);
      g += int'(cur.green === 1'b1);
      s += int'(cur.red === cur.green);
      t += int'(cur !== prev);
      prev = cur;
    end
    check(lnk ? "linkLamp" : "diagLamp", {r[7:0], g[7:0], s[7:0], t[7:0]},
          exp);
  endtask : measure

  task automatic testReset();
    rstN = 1'b0;
    repeat (2) @(posedge sysClk);
    @(negedge sysClk);
    check("rstLamps", {diagLamp, linkLamp, releaseOut}, 32'h0);
    @(posedge sysClk);
    rstN <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    check("ctrl", rd, 32'h1);
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    check("mask", rd, 32'h0);
    apb(1'b1, OFS_STATUS, 32'hff);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("status", rd, 32'ha0);
    apb(1'b0, OFS_LAMPS, 32'h0);
    check("lamps", rd, 32'hc);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped", rd, 32'h0);
    check("slverr", err, 1'b1);
  endtask : testReset

  task automatic testAxis();
    @(posedge sysClk);
    beamActive <= 8'h5a;
    txSupplyOk <= 1'b1;
    repeat (2) @(posedge sysClk);
    @(negedge sysClk);
    check("axis", txAxisLamp, 8'h5a);
    @(posedge sysClk);
    txSupplyOk <= 1'b0;
    repeat (2) @(posedge sysClk);
    @(negedge sysClk);
    check("axisOff", txAxisLamp, 8'h00);
  endtask : testAxis

  task automatic diagCase(input logic [2:0] f, input logic [31:0] exp);
    @(posedge sysClk);
    {intFault, extFault, weakSignal} <= f;
    repeat (2) @(posedge sysClk);
    measure(1'b0, exp);
  endtask : diagCase

  task automatic testDiag();
    diagCase(3'h7, 32'h10001010);
    diagCase(3'h3, 32'h10001004);
    diagCase(3'h1, 32'h00101004);
    diagCase(3'h0, 32'h00002000);
  endtask : testDiag

  task automatic press();
    @(posedge sysClk);
    restartButton <= 1'b1;
    @(posedge sysClk);
    restartButton <= 1'b0;
    @(negedge sysClk);
  endtask : press

  task automatic testInterlock();
    measure(1'b1, 32'h20202000);
    @(posedge sysClk);
    beamBlocked <= 8'h01;
    press();
    check("pressBlocked", releaseOut, 1'b0);
    @(posedge sysClk);
    beamBlocked <= 8'h00;
    repeat (2) @(negedge sysClk);
    check("noAutoStart", releaseOut, 1'b0);
    press();
    check("released", releaseOut, 1'b1);
    repeat (2) @(negedge sysClk);
    check("linkUnlocked", linkLamp, LAMP_OFF);
    @(posedge sysClk);
    beamBlocked <= 8'h80;
    @(negedge sysClk);
    check("beamDrop", releaseOut, 1'b0);
    // The break must still stand at a rising edge to relock the interlock.
    @(posedge sysClk);
    beamBlocked <= 8'h00;
    repeat (3) @(negedge sysClk);
    check("relocked", releaseOut, 1'b0);
  endtask : testInterlock

  task automatic testBus();
    apb(1'b1, OFS_CTRL, 32'h3);
    for (int m = 0; m < 6; m++)
    begin
      @(posedge sysClk);
      asiMode <= m[2:0];
      repeat (2) @(posedge sysClk);
      measure(1'b1, busExp[m]);
    end
    apb(1'b1, OFS_CTRL, 32'h1);
    asiMode <= 3'h0;
  endtask : testBus

  // Event bits are sticky, so earlier scenarios are cleared first.
  task automatic testIrq();
    apb(1'b1, OFS_IRQ_STAT, 32'h1f);
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    weakSignal <= 1'b1;
    repeat (3) @(negedge sysClk);
    check("irqMasked", irq, 1'b0);
    @(posedge sysClk);
    weakSignal <= 1'b0;
    extFault <= 1'b1;
    repeat (3) @(negedge sysClk);
    check("irqSet", irq, 1'b1);
    @(posedge sysClk);
    extFault <= 1'b0;
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    check("irqStat", rd, 32'ha);
    apb(1'b1, OFS_IRQ_STAT, 32'h2);
    @(negedge sysClk);
    check("irqClr", irq, 1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'ha);
    @(negedge sysClk);
    check("irqWeak", irq, 1'b1);
  endtask : testIrq

  initial
  begin
    repeat (20000) @(posedge sysClk);
    failCount++;
    closeOut();
  end

  initial
  begin
    apbReq = '0;
    beamActive = '0;
    beamBlocked = '0;
    {txSupplyOk, extFault, intFault, weakSignal, restartButton} = '0;
    asiMode = 3'h0;
    testReset();
    testAxis();
    testDiag();
    testInterlock();
    testBus();
    testIrq();
    closeOut();
  end
endmodule : status_lamps_tb
